// ==== hw/rxeq_consts.svh ====
`ifndef RXEQ_CONSTS_SVH
`define RXEQ_CONSTS_SVH

// register offsets: the port select, then the registers of the per-port window
`define RXEQ_OFS_PORT_SEL 8'h4C
`define RXEQ_OFS_CTL 8'hD2
`define RXEQ_OFS_STATE 8'hD3
`define RXEQ_OFS_OVR 8'hD4
`define RXEQ_OFS_LIM 8'hD5
`define RXEQ_OFS_SF_A 8'hD6
`define RXEQ_OFS_SF_B 8'hD7

// reset values
`define RXEQ_RST_CTL 8'h94
`define RXEQ_RST_OVR 8'h60
`define RXEQ_RST_LIM 8'hF2
`define RXEQ_RST_ZERO 8'h00

// equalizer_adapt_control fields
`define RXEQ_CTL_RELOCK_HI 7
`define RXEQ_CTL_RELOCK_LO 5
`define RXEQ_CTL_FIRST 4
`define RXEQ_CTL_RESTART 3
`define RXEQ_CTL_FLOOR_EN 2
`define RXEQ_CTL_WR_MASK 8'hF4

// equalizer_manual_override fields
`define RXEQ_OVR_HIGH_HI 7
`define RXEQ_OVR_HIGH_LO 5
`define RXEQ_OVR_LOCKMODE 4
`define RXEQ_OVR_LOW_HI 3
`define RXEQ_OVR_LOW_LO 1
`define RXEQ_OVR_BYPASS 0

// equalizer_range_limits fields
`define RXEQ_LIM_CEIL_HI 7
`define RXEQ_LIM_CEIL_LO 4
`define RXEQ_LIM_FLOOR_HI 3
`define RXEQ_LIM_FLOOR_LO 0

// sampling filter status fields
`define RXEQ_SF_LIMIT 7
`define RXEQ_SF_SETTLED 6
`define RXEQ_SF_FAULT 6
`define RXEQ_SF_DLY_W 6

// relock wait times in ns, and the clock period in ns
`define RXEQ_CLK_PERIOD_NS 5
`define RXEQ_RELOCK_T0_NS 164000
`define RXEQ_RELOCK_T1_NS 328000
`define RXEQ_RELOCK_T2_NS 655000
`define RXEQ_RELOCK_T3_NS 1310000
`define RXEQ_RELOCK_T4_NS 2620000
`define RXEQ_RELOCK_T5_NS 5240000
`define RXEQ_RELOCK_T6_NS 10500000
`define RXEQ_RELOCK_T7_NS 21000000

`endif

// ==== hw/rxeq_pkg.sv ====
package rxeq_pkg;
    typedef enum logic {
        RXEQ_ST_ADAPT,
        RXEQ_ST_DONE
    } rxeq_state_e;
    typedef logic [5:0] rxeq_eq_t;
    typedef logic [3:0] rxeq_step_t;
endpackage

// ==== hw/rxeq_adapt_engine.sv ====
`timescale 1ns/1ps
`include "rxeq_consts.svh"
module rxeq_adapt_engine #(
    parameter int unsigned CNT_W = 23,
    parameter int unsigned RELOCK_CYC [0:7] = '{default: 1}
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // settings
    input wire logic [2:0] i_relock_wait_select,
    input wire logic i_first_lock_zero_start,
    input wire logic i_adapt_restart,
    input wire logic i_floor_start_enable,
    input wire rxeq_pkg::rxeq_step_t i_eq_start_floor,
    input wire rxeq_pkg::rxeq_step_t i_eq_ceiling,
    input wire logic i_adapt_disable,
    input wire rxeq_pkg::rxeq_eq_t i_manual_eq,
    input wire logic i_lock_waits_for_adapt,
    // front end
    input wire logic i_lock_raw,
    // results
    output rxeq_pkg::rxeq_eq_t o_eq_setting,
    output logic o_lock,
    output logic o_adapt_done
);
    rxeq_pkg::rxeq_state_e state;
    rxeq_pkg::rxeq_step_t step;
    rxeq_pkg::rxeq_step_t start_step;
    logic [CNT_W-1:0] wait_cnt;
    logic init_pend;
    logic lock_seen;
    logic expired;
    logic first_lock;

    function automatic logic [CNT_W-1:0] wait_limit(input logic [2:0] sel);
        wait_limit = CNT_W'(RELOCK_CYC[sel] - 1);
    endfunction

    // a floor above the ceiling would escape the limit, so clamp it
    assign start_step = !i_floor_start_enable ? 4'h0 :
        (i_eq_start_floor > i_eq_ceiling) ? i_eq_ceiling :
        i_eq_start_floor;
    assign expired = wait_cnt >= wait_limit(i_relock_wait_select);
    assign first_lock = i_lock_raw && !lock_seen;

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            lock_seen <= 1'b0;
        end else if (i_adapt_restart) begin
            lock_seen <= 1'b0;
        end else if (i_lock_raw) begin
            lock_seen <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            wait_cnt <= '0;
        end else if (i_adapt_restart || init_pend || expired ||
                     state == rxeq_pkg::RXEQ_ST_DONE) begin
            wait_cnt <= '0;
        end else begin
            wait_cnt <= wait_cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            init_pend <= 1'b1;
            step <= 4'h0;
            state <= rxeq_pkg::RXEQ_ST_ADAPT;
        end else begin
            init_pend <= 1'b0;
            if (i_adapt_restart || init_pend) begin
                step <= start_step;
                state <= rxeq_pkg::RXEQ_ST_ADAPT;
            end else if (first_lock && i_first_lock_zero_start) begin
                step <= 4'h0;
                state <= rxeq_pkg::RXEQ_ST_ADAPT;
            end else if (step > i_eq_ceiling) begin
                step <= i_eq_ceiling;
            end else begin
                unique case (state)
                    rxeq_pkg::RXEQ_ST_ADAPT: begin
                        if (expired && !i_adapt_disable) begin
                            if (i_lock_raw) begin
                                state <= rxeq_pkg::RXEQ_ST_DONE;
                            end else if (step >= i_eq_ceiling) begin
                                step <= start_step;
                            end else begin
                                step <= step + 1'b1;
                            end
                        end
                    end
                    rxeq_pkg::RXEQ_ST_DONE: begin
                        if (!i_lock_raw) begin
                            state <= rxeq_pkg::RXEQ_ST_ADAPT;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_eq_setting <= '0;
            o_lock <= 1'b0;
            o_adapt_done <= 1'b0;
        end else begin
            o_eq_setting <= i_adapt_disable ? i_manual_eq : {2'b00, step};
            o_adapt_done <= state == rxeq_pkg::RXEQ_ST_DONE;
            // bypass has nothing to settle, so lock is never held back
            o_lock <= i_lock_raw && (!i_lock_waits_for_adapt ||
                i_adapt_disable ||
                state == rxeq_pkg::RXEQ_ST_DONE);
        end
    end
endmodule

// ==== hw/rxeq_port_regs.sv ====
`timescale 1ns/1ps
`include "rxeq_consts.svh"
module rxeq_port_regs #(
    parameter int unsigned N_PORTS = 4,
    parameter int unsigned CNT_W = 23,
    parameter int unsigned RELOCK_CYC [0:7] = '{
        `RXEQ_RELOCK_T0_NS / `RXEQ_CLK_PERIOD_NS,
        `RXEQ_RELOCK_T1_NS / `RXEQ_CLK_PERIOD_NS,
        `RXEQ_RELOCK_T2_NS / `RXEQ_CLK_PERIOD_NS,
        `RXEQ_RELOCK_T3_NS / `RXEQ_CLK_PERIOD_NS,
        `RXEQ_RELOCK_T4_NS / `RXEQ_CLK_PERIOD_NS,
        `RXEQ_RELOCK_T5_NS / `RXEQ_CLK_PERIOD_NS,
        `RXEQ_RELOCK_T6_NS / `RXEQ_CLK_PERIOD_NS,
        `RXEQ_RELOCK_T7_NS / `RXEQ_CLK_PERIOD_NS
    }
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // register access from the i2c slave
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // receiver front end, one slice per port
    input wire logic [N_PORTS-1:0] i_lock_raw,
    input wire logic [N_PORTS-1:0] i_sampler_limit_hit,
    input wire logic [N_PORTS-1:0] i_sampler_settled,
    input wire logic [N_PORTS-1:0] i_sampler_measure_fault,
    input wire logic [N_PORTS*6-1:0] i_sampler_clock_delay,
    input wire logic [N_PORTS*6-1:0] i_sampler_data_delay,
    // equalizer controls to the front end
    output logic [N_PORTS*6-1:0] o_eq_setting,
    output logic [N_PORTS-1:0] o_lock,
    output logic [N_PORTS-1:0] o_adapt_done
);
    localparam int unsigned PS_W = (N_PORTS > 1) ? $clog2(N_PORTS) : 1;

    if (N_PORTS < 1 || N_PORTS > 8) begin : g_bad_ports
        $error("N_PORTS must be 1 to 8");
    end
    if (CNT_W < 2 || CNT_W > 31) begin : g_bad_cnt
        $error("CNT_W must be 2 to 31");
    end
    // a zero window would wrap the limit, a long one would not fit the count
    for (genvar r = 0; r < 8; r++) begin : g_chk_relock
        if (RELOCK_CYC[r] < 1 ||
            64'(RELOCK_CYC[r]) > (64'd1 << CNT_W)) begin : g_bad_relock
            $error("RELOCK_CYC entries must be 1 to 2**CNT_W");
        end
    end

    logic [PS_W-1:0] port_sel;
    logic [7:0] ctl [N_PORTS];
    logic [7:0] ovr [N_PORTS];
    logic [7:0] lim [N_PORTS];
    logic [N_PORTS-1:0] restart_q;
    logic [N_PORTS-1:0] limit_hit;
    logic [N_PORTS-1:0] settled;
    logic [N_PORTS-1:0] fault;
    logic sel_ok;
    logic [7:0] next_rdata;

    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] ofs);
        hit = addr == ofs;
    endfunction

    // a select beyond the port count reaches no copy at all
    assign sel_ok = 32'(port_sel) < N_PORTS;

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            port_sel <= '0;
        end else if (i_reg_wr && hit(i_reg_addr, `RXEQ_OFS_PORT_SEL)) begin
            port_sel <= i_reg_wdata[PS_W-1:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            for (int p = 0; p < N_PORTS; p++) begin
                ctl[p] <= `RXEQ_RST_CTL;
                ovr[p] <= `RXEQ_RST_OVR;
                lim[p] <= `RXEQ_RST_LIM;
            end
        end else if (i_reg_wr && sel_ok) begin
            // restart and reserved bits are never stored
            if (hit(i_reg_addr, `RXEQ_OFS_CTL)) begin
                ctl[port_sel] <= i_reg_wdata & `RXEQ_CTL_WR_MASK;
            end
            if (hit(i_reg_addr, `RXEQ_OFS_OVR)) begin
                ovr[port_sel] <= i_reg_wdata;
            end
            if (hit(i_reg_addr, `RXEQ_OFS_LIM)) begin
                lim[port_sel] <= i_reg_wdata;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            restart_q <= '0;
        end else begin
            for (int p = 0; p < N_PORTS; p++) begin
                // one-cycle pulse; writing 0 does nothing
                restart_q[p] <= i_reg_wr && sel_ok &&
                    32'(port_sel) == p &&
                    hit(i_reg_addr, `RXEQ_OFS_CTL) &&
                    i_reg_wdata[`RXEQ_CTL_RESTART];
            end
        end
    end

    // status flags: a set in the read cycle survives the clear
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            limit_hit <= '0;
            settled <= '0;
            fault <= '0;
        end else begin
            for (int p = 0; p < N_PORTS; p++) begin
                if (i_reg_rd && sel_ok && 32'(port_sel) == p &&
                    hit(i_reg_addr, `RXEQ_OFS_SF_A)) begin
                    limit_hit[p] <= i_sampler_limit_hit[p];
                    settled[p] <= i_sampler_settled[p];
                end else begin
                    limit_hit[p] <= limit_hit[p] |
                        i_sampler_limit_hit[p];
                    settled[p] <= settled[p] & i_sampler_settled[p];
                end
                if (i_reg_rd && sel_ok && 32'(port_sel) == p &&
                    hit(i_reg_addr, `RXEQ_OFS_SF_B)) begin
                    fault[p] <= i_sampler_measure_fault[p];
                end else begin
                    fault[p] <= fault[p] | i_sampler_measure_fault[p];
                end
            end
        end
    end

    always_comb begin
        next_rdata = `RXEQ_RST_ZERO;
        if (hit(i_reg_addr, `RXEQ_OFS_PORT_SEL)) begin
            next_rdata[PS_W-1:0] = port_sel;
        end else if (sel_ok) begin
            unique case (i_reg_addr)
                `RXEQ_OFS_CTL: next_rdata = ctl[port_sel];
                `RXEQ_OFS_STATE: begin
                    next_rdata[5:0] = o_eq_setting[port_sel*6 +: 6];
                end
                `RXEQ_OFS_OVR: next_rdata = ovr[port_sel];
                `RXEQ_OFS_LIM: next_rdata = lim[port_sel];
                `RXEQ_OFS_SF_A: begin
                    next_rdata[`RXEQ_SF_LIMIT] = limit_hit[port_sel];
                    next_rdata[`RXEQ_SF_SETTLED] = settled[port_sel];
                    next_rdata[`RXEQ_SF_DLY_W-1:0] =
                        i_sampler_clock_delay[port_sel*6 +: 6];
                end
                `RXEQ_OFS_SF_B: begin
                    next_rdata[`RXEQ_SF_FAULT] = fault[port_sel];
                    next_rdata[`RXEQ_SF_DLY_W-1:0] =
                        i_sampler_data_delay[port_sel*6 +: 6];
                end
                default: next_rdata = `RXEQ_RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_reg_rdata <= `RXEQ_RST_ZERO;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= next_rdata;
            end
        end
    end

    for (genvar g = 0; g < N_PORTS; g++) begin : g_port
        rxeq_adapt_engine #(
            .CNT_W(CNT_W),
            .RELOCK_CYC(RELOCK_CYC)
        ) u_engine (
            .i_clk_sys(i_clk_sys),
            .i_reset_n(i_reset_n),
            .i_relock_wait_select(
                ctl[g][`RXEQ_CTL_RELOCK_HI:`RXEQ_CTL_RELOCK_LO]),
            .i_first_lock_zero_start(ctl[g][`RXEQ_CTL_FIRST]),
            .i_adapt_restart(restart_q[g]),
            .i_floor_start_enable(ctl[g][`RXEQ_CTL_FLOOR_EN]),
            .i_eq_start_floor(
                lim[g][`RXEQ_LIM_FLOOR_HI:`RXEQ_LIM_FLOOR_LO]),
            .i_eq_ceiling(lim[g][`RXEQ_LIM_CEIL_HI:`RXEQ_LIM_CEIL_LO]),
            .i_adapt_disable(ovr[g][`RXEQ_OVR_BYPASS]),
            .i_manual_eq({ovr[g][`RXEQ_OVR_HIGH_HI:`RXEQ_OVR_HIGH_LO],
                ovr[g][`RXEQ_OVR_LOW_HI:`RXEQ_OVR_LOW_LO]}),
            .i_lock_waits_for_adapt(ovr[g][`RXEQ_OVR_LOCKMODE]),
            .i_lock_raw(i_lock_raw[g]),
            .o_eq_setting(o_eq_setting[g*6 +: 6]),
            .o_lock(o_lock[g]),
            .o_adapt_done(o_adapt_done[g])
        );
    end
endmodule

// ==== verification/rxeq_fe_model.sv ====
`timescale 1ns/1ps
module rxeq_fe_model #(
    parameter int unsigned N_PORTS = 2
) (
    // clock
    input wire logic i_clk_sys,
    // applied setting and cable need per port
    input wire logic [N_PORTS*6-1:0] i_eq_setting,
    input wire logic [N_PORTS*6-1:0] i_eq_need,
    // lock detector
    output logic [N_PORTS-1:0] o_lock_raw
);
    initial begin
        o_lock_raw = '0;
    end
    // lock only once the setting covers the cable loss, one cycle late
    always @(posedge i_clk_sys) begin
        for (int p = 0; p < N_PORTS; p++) begin
            o_lock_raw[p] <= i_eq_setting[6*p +: 6] >= i_eq_need[6*p +: 6];
        end
    end
endmodule

// ==== verification/rxeq_port_regs_chk.sv ====
`timescale 1ns/1ps
module rxeq_port_regs_chk #(
    parameter int unsigned N_PORTS = 4
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    // front end
    input wire logic [N_PORTS-1:0] i_lock_raw,
    input wire logic [N_PORTS-1:0] i_sampler_settled,
    input wire logic [N_PORTS-1:0] o_lock,
    input wire logic [N_PORTS-1:0] o_adapt_done
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);
    logic unmapped;
    assign unmapped = !(i_reg_addr == 8'h4C ||
        (i_reg_addr >= 8'hD2 && i_reg_addr <= 8'hD7));
    AST_RVALID: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("no read answer");
    AST_NO_RVALID: assert property (!i_reg_rd |=> !o_reg_rvalid)
        else $error("read answer without read");
    AST_RDATA_HOLD: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data moved without read");
    AST_UNMAPPED: assert property (i_reg_rd && unmapped |=>
        o_reg_rdata == 8'h00) else $error("unmapped read not zero");
    AST_STATE_TOP: assert property (i_reg_rd && i_reg_addr == 8'hD3
        |=> o_reg_rdata[7:6] == 2'b00) else $error("state top bits set");
    AST_CTL_RSVD: assert property (i_reg_rd && i_reg_addr == 8'hD2
        |=> o_reg_rdata[3] == 1'b0 && o_reg_rdata[1:0] == 2'b00)
        else $error("control restart or spare bits read set");
    AST_SF_B_TOP: assert property (i_reg_rd && i_reg_addr == 8'hD7
        |=> !o_reg_rdata[7]) else $error("filter status b top bit set");
    AST_SETTLED: assert property (i_reg_rd && i_reg_addr == 8'hD6 &&
        $past(i_sampler_settled) == '0 |=> !o_reg_rdata[6])
        else $error("settled flag not latched low");
    AST_LOCK_RAW: assert property ((o_lock & ~$past(i_lock_raw)) == '0)
        else $error("lock reported without detector lock");
    AST_DONE_RAW: assert property ($rose(o_adapt_done[0]) |->
        $past(i_lock_raw[0], 2)) else $error("adaptation done without lock");
endmodule
bind rxeq_port_regs rxeq_port_regs_chk #(.N_PORTS(N_PORTS)) u_chk (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_reg_addr(i_reg_addr),
    .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid),
    .i_lock_raw(i_lock_raw),
    .i_sampler_settled(i_sampler_settled),
    .o_lock(o_lock),
    .o_adapt_done(o_adapt_done)
);

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb;
    localparam int unsigned NP = 2;
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [NP-1:0] sf_limit = '0;
    logic [NP-1:0] sf_settled = '1;
    logic [NP-1:0] sf_fault = '0;
    logic [NP*6-1:0] cdly = '0;
    logic [NP*6-1:0] ddly = '0;
    logic [NP*6-1:0] need = '1;
    logic [NP*6-1:0] o_eq_setting;
    logic [NP-1:0] lock_raw;
    logic [NP-1:0] o_lock;
    logic [NP-1:0] o_adapt_done;
    logic [7:0] o_reg_rdata;
    logic o_reg_rvalid;
    logic [5:0] top;
    int n_errors = 0;
    int checks = 0;
    logic [7:0] ta [7] = '{8'h4C, 8'hD2, 8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'hD0};
    logic [7:0] te [7] = '{8'h00, 8'h94, 8'h60, 8'hF2, 8'h00, 8'h00, 8'h00};

    initial begin
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    rxeq_port_regs #(.N_PORTS(NP), .RELOCK_CYC('{8, 16, 32, 64, 128, 256,
        512, 1024})) dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .o_reg_rvalid(o_reg_rvalid), .i_lock_raw(lock_raw),
        .i_sampler_limit_hit(sf_limit), .i_sampler_settled(sf_settled),
        .i_sampler_measure_fault(sf_fault), .i_sampler_clock_delay(cdly),
        .i_sampler_data_delay(ddly), .o_eq_setting(o_eq_setting),
        .o_lock(o_lock), .o_adapt_done(o_adapt_done));

    rxeq_fe_model #(.N_PORTS(NP)) u_fe (.i_clk_sys(i_clk_sys),
        .i_eq_setting(o_eq_setting), .i_eq_need(need),
        .o_lock_raw(lock_raw));

    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic hang(input string what);
        n_errors++;
        $display("ERROR %s expected answer seen none", what);
        results();
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
    endtask

    // the answer is taken at the edge that shows rvalid high
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        int k;
        @(posedge i_clk_sys);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b0;
        for (k = 0; k < 4; k++) begin
            @(posedge i_clk_sys);
            if (o_reg_rvalid === 1'b1) break;
        end
        if (k == 4) hang("read answer");
        cmp($sformatf("reg %h", a), e, o_reg_rdata);
    endtask

    task automatic wait_done();
        int k;
        for (k = 0; k < 3000 && o_adapt_done[0] !== 1'b1; k++) begin
            @(posedge i_clk_sys);
        end
        if (k == 3000) hang("adaptation done");
    endtask

    initial begin
        repeat (5) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        for (int i = 0; i < 7; i++) rdc(ta[i], te[i]);
        rdc(8'hD3, 8'h02);
        wr(8'hD2, 8'hFF);
        rdc(8'hD2, 8'hF4);
        $display("test reset and access done");
        wr(8'hD2, 8'h0C);
        need[5:0] <= 6'd5;
        wait_done();
        cmp("eq step", 8'h05, {2'b00, o_eq_setting[5:0]});
        rdc(8'hD3, 8'h05);
        wr(8'hD5, 8'h32);
        need[5:0] <= 6'd9;
        wr(8'hD2, 8'h0C);
        top = '0;
        repeat (200) begin
            @(posedge i_clk_sys);
            if (o_eq_setting[5:0] > top) top = o_eq_setting[5:0];
        end
        cmp("eq ceiling", 8'h03, {2'b00, top});
        $display("test stepping done");
        wr(8'hD5, 8'hF2);
        wr(8'hD2, 8'h1C);
        need[5:0] <= 6'd1;
        wait_done();
        cmp("first lock", 8'h01, {2'b00, o_eq_setting[5:0]});
        wr(8'hD4, 8'h70);
        wr(8'hD2, 8'h4C);
        repeat (8) @(posedge i_clk_sys);
        cmp("lock while adapting", 8'h00, {7'd0, o_lock[0]});
        wait_done();
        repeat (2) @(posedge i_clk_sys);
        cmp("lock after adapting", 8'h01, {7'd0, o_lock[0]});
        wr(8'hD4, 8'h60);
        wr(8'hD2, 8'h4C);
        repeat (8) @(posedge i_clk_sys);
        cmp("lock detector only", 8'h01, {7'd0, o_lock[0]});
        wr(8'hD4, 8'hA7);
        repeat (3) @(posedge i_clk_sys);
        cmp("bypass eq", 8'h2B, {2'b00, o_eq_setting[5:0]});
        wr(8'hD4, 8'h60);
        $display("test lock and bypass done");
        wr(8'h4C, 8'h01);
        @(posedge i_clk_sys);
        sf_limit <= 2'b10;
        sf_settled <= 2'b01;
        sf_fault <= 2'b10;
        cdly <= {6'h2A, 6'h00};
        ddly <= {6'h15, 6'h00};
        @(posedge i_clk_sys);
        sf_limit <= '0;
        sf_settled <= '1;
        sf_fault <= '0;
        rdc(8'hD6, 8'hAA);
        rdc(8'hD6, 8'h6A);
        rdc(8'hD7, 8'h55);
        rdc(8'hD7, 8'h15);
        // settled low across a read, then back high: stays low until read
        sf_settled <= '0;
        rdc(8'hD6, 8'h2A);
        sf_settled <= '1;
        rdc(8'hD6, 8'h2A);
        rdc(8'hD6, 8'h6A);
        wr(8'hD5, 8'hA1);
        rdc(8'hD5, 8'hA1);
        wr(8'h4C, 8'h00);
        rdc(8'hD5, 8'hF2);
        $display("test sampler and ports done");
        results();
    end
endmodule
